// [logic/etsr_defs.vh]
// Register map, field layout and reset values of the sample readout block.
// Assumes a 32-bit AHB-Lite register bus with word-aligned byte addresses.
`ifndef ETSR_DEFS_VH
`define ETSR_DEFS_VH
`define ETSR_OFS_S2_NS 12'h560
`define ETSR_OFS_S2_SEC 12'h564
`define ETSR_OFS_S2_PHASE 12'h568
`define ETSR_OFS_S3_NS 12'h56c
`define ETSR_OFS_S3_SEC 12'h570
`define ETSR_OFS_S3_PHASE 12'h574
`define ETSR_OFS_UNIT_INDEX 12'h500
`define ETSR_UNIT_PTR_BIT 8
`define ETSR_POL_BIT 30
`define ETSR_NS_W 30
`define ETSR_PHASE_W 3
`define ETSR_RST_WORD 32'h0000_0000
`define ETSR_RST_PHASE 3'h0
`define ETSR_PHASE_0NS 3'h0
`define ETSR_PHASE_8NS 3'h1
`define ETSR_PHASE_16NS 3'h2
`define ETSR_PHASE_24NS 3'h3
`define ETSR_PHASE_32NS 3'h4
`define ETSR_SLOT_COUNT 3'h5
`define ETSR_HTRANS_NONSEQ 2'h2
`endif

// [logic/etsr_sample_readout.v]
// Second and third event-capture sample registers, two timestamp units,
// read over AHB-Lite.
// Assumes a capture engine outside supplies per-unit samples with a load strobe.
// Assumes hready is the bus's own ready, driven back from hreadyout.
// Assumes a single pointer bit, so only units 0 and 1 can ever be shown.
// Assumes hsize is always a whole word; it is not checked.
//
// How it works
// - Sample-2 ns bit30 polarity, bit31 zero
// - Sample-2 ns bits29:0, reset zero
// - Sample-2 seconds 32 bits, reset zero
// - Sample-2 phase bits2:0, upper zero, reset 000
// - Sample-3 ns bit30 polarity, bit31 zero
// - Sample-3 ns bits29:0, reset zero
// - Sample-3 seconds 32 bits, reset zero
// - Sample-3 phase bits2:0, upper zero
// - Unit index bit8 selects presented unit
// - Phase: five 8ns slots per 40ns
`include "etsr_defs.vh"
`default_nettype none

module etsr_sample_readout #(
  parameter UNITS = 2
) (
  // Clock, reset and the AHB-Lite slave port
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Second-sample capture inputs; unit u sits at slice u of each field
  input wire [UNITS-1:0] cap2_load,
  input wire [UNITS-1:0] cap2_polarity,
  input wire [UNITS*30-1:0] cap2_nanoseconds,
  input wire [UNITS*32-1:0] cap2_seconds,
  input wire [UNITS*3-1:0] cap2_phase_slot,
  // Third-sample capture inputs, packed the same way
  input wire [UNITS-1:0] cap3_load,
  input wire [UNITS-1:0] cap3_polarity,
  input wire [UNITS*30-1:0] cap3_nanoseconds,
  input wire [UNITS*32-1:0] cap3_seconds,
  input wire [UNITS*3-1:0] cap3_phase_slot,
  // Current unit pointer, for whoever routes the capture engine
  output wire unit_index_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Per-unit sample storage
  // Every field is packed with unit u at slice u times the field width.
  // Capture writes only through the next-value logic below; the bus has
  // no path into these registers, so software can never alter a sample.

  localparam NS_W = `ETSR_NS_W;
  localparam PH_W = `ETSR_PHASE_W;
  localparam SEC_W = 32;

  // Second-sample fields, current and next
  reg [UNITS-1:0] second_capture_polarity_r;
  reg [UNITS*NS_W-1:0] second_capture_nanoseconds_r;
  reg [UNITS*SEC_W-1:0] second_capture_seconds_r;
  reg [UNITS*PH_W-1:0] second_capture_phase_slot_r;
  reg [UNITS-1:0] second_capture_polarity_nxt;
  reg [UNITS*NS_W-1:0] second_capture_nanoseconds_nxt;
  reg [UNITS*SEC_W-1:0] second_capture_seconds_nxt;
  reg [UNITS*PH_W-1:0] second_capture_phase_slot_nxt;

  // Third-sample fields, current and next
  reg [UNITS-1:0] third_capture_polarity_r;
  reg [UNITS*NS_W-1:0] third_capture_nanoseconds_r;
  reg [UNITS*SEC_W-1:0] third_capture_seconds_r;
  reg [UNITS*PH_W-1:0] third_capture_phase_slot_r;
  reg [UNITS-1:0] third_capture_polarity_nxt;
  reg [UNITS*NS_W-1:0] third_capture_nanoseconds_nxt;
  reg [UNITS*SEC_W-1:0] third_capture_seconds_nxt;
  reg [UNITS*PH_W-1:0] third_capture_phase_slot_nxt;

  // Loop indices of the next-value processes
  integer u2;
  integer u3;

  // Slot codes beyond the fifth slot are reserved; clamp them to 0ns
  // so a faulty capture code never reaches software as a reserved value
  function [2:0] etsr_slot_clean;
    input [2:0] code;
    begin
      if (code < `ETSR_SLOT_COUNT) begin
        etsr_slot_clean = code;
      end else begin
        etsr_slot_clean = `ETSR_PHASE_0NS;
      end
    end
  endfunction

  // Next second-sample values: a unit's strobe replaces all its fields at once,
  // so a read never mixes the time of one event with the edge of another.
  // Without a strobe every field holds, whatever the bus does.
  always @* begin
    second_capture_polarity_nxt = second_capture_polarity_r;
    second_capture_nanoseconds_nxt = second_capture_nanoseconds_r;
    second_capture_seconds_nxt = second_capture_seconds_r;
    second_capture_phase_slot_nxt = second_capture_phase_slot_r;
    for (u2 = 0; u2 < UNITS; u2 = u2 + 1) begin
      if (cap2_load[u2]) begin
        second_capture_polarity_nxt[u2] = cap2_polarity[u2];
        second_capture_nanoseconds_nxt[u2*NS_W +: NS_W] =
          cap2_nanoseconds[u2*NS_W +: NS_W];
        second_capture_seconds_nxt[u2*SEC_W +: SEC_W] =
          cap2_seconds[u2*SEC_W +: SEC_W];
        second_capture_phase_slot_nxt[u2*PH_W +: PH_W] =
          etsr_slot_clean(cap2_phase_slot[u2*PH_W +: PH_W]);
      end
    end
  end

  // Next third-sample values, built the same way as the second sample's;
  // the two samples have separate strobes and never disturb each other.
  // Without a strobe every field holds, whatever the bus does.
  always @* begin
    third_capture_polarity_nxt = third_capture_polarity_r;
    third_capture_nanoseconds_nxt = third_capture_nanoseconds_r;
    third_capture_seconds_nxt = third_capture_seconds_r;
    third_capture_phase_slot_nxt = third_capture_phase_slot_r;
    for (u3 = 0; u3 < UNITS; u3 = u3 + 1) begin
      if (cap3_load[u3]) begin
        third_capture_polarity_nxt[u3] = cap3_polarity[u3];
        third_capture_nanoseconds_nxt[u3*NS_W +: NS_W] =
          cap3_nanoseconds[u3*NS_W +: NS_W];
        third_capture_seconds_nxt[u3*SEC_W +: SEC_W] =
          cap3_seconds[u3*SEC_W +: SEC_W];
        third_capture_phase_slot_nxt[u3*PH_W +: PH_W] =
          etsr_slot_clean(cap3_phase_slot[u3*PH_W +: PH_W]);
      end
    end
  end

  // Second-sample registers; reset clears every unit to zero.
  // One process holds all units so each register has a single driver,
  // and the reset branch assigns constants only.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      second_capture_polarity_r <= {UNITS{1'b0}};
      second_capture_nanoseconds_r <= {UNITS*NS_W{1'b0}};
      second_capture_seconds_r <= {UNITS{`ETSR_RST_WORD}};
      second_capture_phase_slot_r <= {UNITS{`ETSR_RST_PHASE}};
    end else begin
      second_capture_polarity_r <= second_capture_polarity_nxt;
      second_capture_nanoseconds_r <= second_capture_nanoseconds_nxt;
      second_capture_seconds_r <= second_capture_seconds_nxt;
      second_capture_phase_slot_r <= second_capture_phase_slot_nxt;
    end
  end

  // Third-sample registers; reset clears every unit to zero.
  // One process holds all units so each register has a single driver,
  // and the reset branch assigns constants only.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      third_capture_polarity_r <= {UNITS{1'b0}};
      third_capture_nanoseconds_r <= {UNITS*NS_W{1'b0}};
      third_capture_seconds_r <= {UNITS{`ETSR_RST_WORD}};
      third_capture_phase_slot_r <= {UNITS{`ETSR_RST_PHASE}};
    end else begin
      third_capture_polarity_r <= third_capture_polarity_nxt;
      third_capture_nanoseconds_r <= third_capture_nanoseconds_nxt;
      third_capture_seconds_r <= third_capture_seconds_nxt;
      third_capture_phase_slot_r <= third_capture_phase_slot_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: address phase capture
  // Only single word transfers are expected; hsize and burst types are ignored

  reg addr_valid_r;
  reg addr_write_r;
  reg [11:0] addr_r;
  reg unit_index_r;
  wire addr_take;

  // The slave never waits and never errors; the pointer is shown as a port
  assign addr_take = hsel && hready && (htrans == `ETSR_HTRANS_NONSEQ);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign unit_index_out = unit_index_r;

  // Latch the address phase for the following data phase.
  // Write data arrives one cycle after its address, so the decode of a
  // write must use this copy and not the live address bus.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_valid_r <= 1'b0;
      addr_write_r <= 1'b0;
      addr_r <= 12'h000;
    end else if (hready) begin
      addr_valid_r <= addr_take;
      addr_write_r <= hwrite;
      addr_r <= haddr;
    end
  end

  // Unit index pointer: the only writable bit of this block.
  // Writes to any other offset, the sample words included, are dropped here;
  // a read right behind a pointer write still sees the old unit.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_index_r <= 1'b0;
    end else if (addr_valid_r && addr_write_r && addr_r == `ETSR_OFS_UNIT_INDEX) begin
      unit_index_r <= hwdata[`ETSR_UNIT_PTR_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Selected unit view: the pointer picks one unit's fields for readout.
  // A unit that does not exist reads as zeros rather than stale data.
  // The choice is made from the pointer as it stands in the address phase.

  reg sel_s2_polarity;
  reg [NS_W-1:0] sel_s2_nanoseconds;
  reg [SEC_W-1:0] sel_s2_seconds;
  reg [PH_W-1:0] sel_s2_phase_slot;
  reg sel_s3_polarity;
  reg [NS_W-1:0] sel_s3_nanoseconds;
  reg [SEC_W-1:0] sel_s3_seconds;
  reg [PH_W-1:0] sel_s3_phase_slot;
  integer us2;
  integer us3;

  // Second-sample fields of the unit the pointer names;
  // every unit is visited so no index ever runs outside the vectors
  always @* begin
    sel_s2_polarity = 1'b0;
    sel_s2_nanoseconds = {NS_W{1'b0}};
    sel_s2_seconds = {SEC_W{1'b0}};
    sel_s2_phase_slot = {PH_W{1'b0}};
    for (us2 = 0; us2 < UNITS; us2 = us2 + 1) begin
      if (us2 == {31'h0000_0000, unit_index_r}) begin
        sel_s2_polarity = second_capture_polarity_r[us2];
        sel_s2_nanoseconds = second_capture_nanoseconds_r[us2*NS_W +: NS_W];
        sel_s2_seconds = second_capture_seconds_r[us2*SEC_W +: SEC_W];
        sel_s2_phase_slot = second_capture_phase_slot_r[us2*PH_W +: PH_W];
      end
    end
  end

  // Third-sample fields of the unit the pointer names;
  // every unit is visited so no index ever runs outside the vectors
  always @* begin
    sel_s3_polarity = 1'b0;
    sel_s3_nanoseconds = {NS_W{1'b0}};
    sel_s3_seconds = {SEC_W{1'b0}};
    sel_s3_phase_slot = {PH_W{1'b0}};
    for (us3 = 0; us3 < UNITS; us3 = us3 + 1) begin
      if (us3 == {31'h0000_0000, unit_index_r}) begin
        sel_s3_polarity = third_capture_polarity_r[us3];
        sel_s3_nanoseconds = third_capture_nanoseconds_r[us3*NS_W +: NS_W];
        sel_s3_seconds = third_capture_seconds_r[us3*SEC_W +: SEC_W];
        sel_s3_phase_slot = third_capture_phase_slot_r[us3*PH_W +: PH_W];
      end
    end
  end

  // Register words as software sees them
  wire [31:0] word_s2_ns;
  wire [31:0] word_s2_sec;
  wire [31:0] word_s2_phase;
  wire [31:0] word_s3_ns;
  wire [31:0] word_s3_sec;
  wire [31:0] word_s3_phase;
  wire [31:0] word_unit_index;

  // Second sample: reserved bits tied to zero
  assign word_s2_ns = {1'b0, sel_s2_polarity, sel_s2_nanoseconds};
  assign word_s2_sec = sel_s2_seconds;
  assign word_s2_phase = {29'h0000_0000, sel_s2_phase_slot};
  // Third sample: reserved bits tied to zero
  assign word_s3_ns = {1'b0, sel_s3_polarity, sel_s3_nanoseconds};
  assign word_s3_sec = sel_s3_seconds;
  assign word_s3_phase = {29'h0000_0000, sel_s3_phase_slot};
  // Pointer register: only the pointer bit is ever set
  assign word_unit_index = {23'h00_0000, unit_index_r, 8'h00};

  ////////////////////////////////////////////////////////////////////////////
  // Read data: the word for the live address, registered at the address edge
  // so it stands for the whole data phase

  reg [31:0] rdata_nxt;

  // Decode the live address; unmapped offsets read as zero.
  // Writes to sample offsets fall through with no effect
  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (haddr)
      // Second-sample words
      `ETSR_OFS_S2_NS: begin
        rdata_nxt = word_s2_ns;
      end
      `ETSR_OFS_S2_SEC: begin
        rdata_nxt = word_s2_sec;
      end
      `ETSR_OFS_S2_PHASE: begin
        rdata_nxt = word_s2_phase;
      end
      // Third-sample words
      `ETSR_OFS_S3_NS: begin
        rdata_nxt = word_s3_ns;
      end
      `ETSR_OFS_S3_SEC: begin
        rdata_nxt = word_s3_sec;
      end
      `ETSR_OFS_S3_PHASE: begin
        rdata_nxt = word_s3_phase;
      end
      // Pointer register
      `ETSR_OFS_UNIT_INDEX: begin
        rdata_nxt = word_unit_index;
      end
      default: begin
        rdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  // Read data stands from the data phase until the next read is taken.
  // Writes leave it alone, so a write never disturbs a word software
  // has yet to sample.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_take && !hwrite) begin
      hrdata <= rdata_nxt;
    end
  end

endmodule

`default_nettype wire

// [sim/etsr_readout_checker.sv]
// Assertions on the sample readout block's bus and pointer ports.
// Assumes zero wait states and read data registered at the address edge.
`default_nettype none
module etsr_readout_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic unit_index_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Transfer taken, read taken
  wire tk = hsel && hready && htrans == 2'h2;
  wire rd = tk && !hwrite;
  ////////////////////////////////////////////////////////////////////////////////
  // Reserved bits and phase range
  a_ns2_top_zero: assert property (rd && haddr == 12'h560 |=> !hrdata[31])
    else $error("ns2 bit31 set");
  a_ns3_top_zero: assert property (rd && haddr == 12'h56c |=> !hrdata[31])
    else $error("ns3 bit31 set");
  a_ph2_upper_zero: assert property (rd && haddr == 12'h568 |=> hrdata[31:3] == 29'h0)
    else $error("phase2 upper set");
  a_ph3_upper_zero: assert property (rd && haddr == 12'h574 |=> hrdata[31:3] == 29'h0)
    else $error("phase3 upper set");
  a_slot_in_range: assert property (rd && haddr inside {12'h568, 12'h574} |=> hrdata[2:0] < 3'h5)
    else $error("phase code reserved");
  // Pointer and read data behaviour
  a_pointer_write: assert property (tk && hwrite && haddr == 12'h500 ##1 1'b1
    |=> unit_index_out == $past(hwdata[8]))
    else $error("pointer not written");
  a_ro_write_kept: assert property (tk && hwrite && haddr != 12'h500 |=> ##1 $stable(unit_index_out))
    else $error("pointer moved");
  a_read_data_holds: assert property (!rd |=> $stable(hrdata))
    else $error("hrdata moved");
endmodule
bind etsr_sample_readout etsr_readout_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .unit_index_out);
`default_nettype wire

// [sim/etsr_sample_readout_test.sv]
// Bench for the sample readout block: captures, pointer moves, ignored writes.
// Assumes zero wait states; driver queues expected words, monitor retires them.
`default_nettype none
module etsr_sample_readout_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = '0, hresetn = '0, hsel = '0, hwrite = '0, hreadyout, hresp, rd_dp = '0;
  logic [11:0] haddr = '0, rd_a = '0;
  logic uio, pq[$];
  logic [1:0] htrans = '0, cap2_load = '0, cap3_load = '0, cap2_polarity = '0, cap3_polarity = '0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0, hrdata, lf = 32'hece3, q[$];
  logic [59:0] cap2_nanoseconds = '0, cap3_nanoseconds = '0;
  logic [63:0] cap2_seconds = '0, cap3_seconds = '0;
  logic [5:0] cap2_phase_slot = '0, cap3_phase_slot = '0;
  int miscompares = 0, tests_run = 0, cyc = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 40 MHz
  always #12.5 hclk = ~hclk;
  etsr_sample_readout DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .cap2_load, .cap2_polarity,
    .cap2_nanoseconds, .cap2_seconds, .cap2_phase_slot, .cap3_load, .cap3_polarity,
    .cap3_nanoseconds, .cap3_seconds, .cap3_phase_slot, .unit_index_out(uio));
  // Helpers: random step, stored phase code, compare, verdict
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] ph(input logic [2:0] k);
    return k > 3'h4 ? 32'h0 : {29'h0, k};
  endfunction
  task automatic chk(input logic [31:0] e);
    tests_run++;
    if (hrdata !== e) begin
      miscompares++;
      $display("mismatch hrdata expected %h seen %h", e, hrdata);
    end
  endtask
  task automatic chk_ptr(input logic e);
    tests_run++;
    if (uio !== e) begin
      miscompares++;
      $display("mismatch unit_index_out expected %b seen %b", e, uio);
    end
  endtask
  task automatic wrap_up;
    if (q.size() != 0 || pq.size() != 0) miscompares++;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // One single transfer; a read queues its expected word
  task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] d, e);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    if (!w) q.push_back(e);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  // Both units capture fresh samples with phase codes from k
  task automatic load(input logic [2:0] k);
    for (int u = 0; u < 2; u++) begin
      lf = nx(lf);
      cap2_nanoseconds[u*30+:30] <= lf[29:0];
      cap3_nanoseconds[u*30+:30] <= ~lf[29:0];
      cap2_seconds[u*32+:32] <= lf;
      cap3_seconds[u*32+:32] <= ~lf;
      cap2_phase_slot[u*3+:3] <= k;
      cap3_phase_slot[u*3+:3] <= k + u[2:0];
    end
    cap2_polarity <= {k[0], ~k[0]};
    cap3_polarity <= {~k[0], k[0]};
    cap2_load <= 2'h3;
    cap3_load <= 2'h3;
    @(posedge hclk);
    cap2_load <= 2'h0;
    cap3_load <= 2'h0;
    @(posedge hclk);
  endtask
  // Select unit u, hit every sample word with writes, then read all back
  task automatic unit(input logic u);
    ahb(12'h500, 1'b1, {23'h0, u, 8'h0}, '0);
    pq.push_back(u);
    ahb(12'h500, 1'b0, '0, {23'h0, u, 8'h0});
    for (int i = 0; i < 6; i++) ahb(12'h560 + 12'(4 * i), 1'b1, nx(lf ^ i), '0);
    ahb(12'h560, 1'b0, '0, {1'b0, cap2_polarity[u], cap2_nanoseconds[u*30+:30]});
    ahb(12'h564, 1'b0, '0, cap2_seconds[u*32+:32]);
    ahb(12'h568, 1'b0, '0, ph(cap2_phase_slot[u*3+:3]));
    ahb(12'h56c, 1'b0, '0, {1'b0, cap3_polarity[u], cap3_nanoseconds[u*30+:30]});
    ahb(12'h570, 1'b0, '0, cap3_seconds[u*32+:32]);
    ahb(12'h574, 1'b0, '0, ph(cap3_phase_slot[u*3+:3]));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Monitor: a read in its data phase retires the oldest note; hang limit
  always @(posedge hclk) begin
    rd_dp <= hsel && hreadyout && htrans == 2'h2 && !hwrite;
    rd_a <= haddr;
    cyc <= cyc + 1;
    if (rd_dp) chk(q.pop_front());
    if (rd_dp && rd_a == 12'h500) chk_ptr(pq.pop_front());
    if (cyc == 3000) begin
      miscompares++;
      wrap_up();
    end
  end
  // Reset, reset values, then eight capture rounds over both units
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 6; i++) ahb(12'h560 + 12'(4 * i), 1'b0, '0, '0);
    $display("test reset_values done");
    for (int k = 0; k < 8; k++) begin
      load(k[2:0]);
      unit(1'b0);
      unit(1'b1);
    end
    $display("test captures done");
    @(posedge hclk);
    wrap_up();
  end
endmodule
`default_nettype wire
